// ### src/ecs_tx_cas_sel.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
module ecs_tx_cas_sel
  import ecs_pkg::*;
#(
  parameter int unsigned ADDR_W = 14
) (
  input  wire logic         CLOCK_IN,   // 20 MHz clock
  input  wire logic         RSTN_IN,    // Async reset, active low
  input  wire logic         PSEL_IN,    // APB select
  input  wire logic         PENABLE_IN, // APB enable
  input  wire logic         PWRITE_IN,  // APB direction
  input  wire logic [ADDR_W-1:0] PADDR_IN, // APB byte address
  input  wire logic [31:0]  PWDATA_IN,  // APB write data
  output logic      [31:0]  PRDATA_OUT, // APB read data
  output logic              PREADY_OUT, // APB ready
  output logic              PSLVERR_OUT,// APB error on unmapped access
  input  wire logic         SIG_VALID_IN, // Timeslot signaling strobe
  input  wire ecs_sig_in_t  SIG_IN,     // Timeslot and candidate nibbles
  input  wire logic         ALARM_IN,   // Current remote alarm condition
  output logic              SIG_VALID_OUT, // Result strobe
  output ecs_sig_out_t      SIG_OUT     // Chosen signaling nibble
);

  // The register map needs fourteen address bits; refuse anything narrower
  if (ADDR_W < 14) begin : g_addr_w_check
    $error("ADDR_W too small for the register map");
  end

  // ****************************************
  // Register bank
  // ****************************************
  logic [7:0]  tx_timeslot_signaling_reg [NUM_TS];
  logic [4:0]  ctrl;
  logic [31:0] rdata;

  wire logic [13:0] addr      = PADDR_IN[13:0];
  wire logic        hi_zero   = (ADDR_W == 14) ? 1'b1 : ~|(PADDR_IN >> 14);
  wire logic        in_bank   = hi_zero && addr[13:7] == SIG_BANK_ADDR[13:7]
                                && addr[1:0] == 2'h0;
  wire logic        is_ctrl   = hi_zero && addr == CTRL_ADDR;
  wire logic        is_status = hi_zero && addr == STATUS_ADDR;
  wire logic        mapped    = in_bank || is_ctrl || is_status;
  wire logic        setup     = PSEL_IN && !PENABLE_IN;
  wire logic        wr_access = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped;
  wire logic [4:0]  bank_idx  = addr[6:2];

  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign PRDATA_OUT  = rdata;

  genvar k;
  generate
    for (k = 0; k < NUM_TS; k++) begin : g_ts
      localparam logic [7:0] RST = (k == 0) ? TS0_RESET :
                                   (k == TS_XYXX) ? TS16_RESET : TS_RESET;
      always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          tx_timeslot_signaling_reg[k] <= RST;
        end else if (wr_access && in_bank && bank_idx == 5'(k)) begin
          tx_timeslot_signaling_reg[k] <= PWDATA_IN[7:0] & WRITE_MASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl <= 5'h00;
    end else if (wr_access && is_ctrl) begin
      ctrl <= PWDATA_IN[4:0] & CTRL_MASK;
    end
  end

  // Read data is captured in the setup cycle so the access needs no wait state
  wire logic [31:0] status_word = {28'h0, SIG_OUT.xyxx, SIG_OUT.insert, SIG_OUT.src};
  wire logic [31:0] next_rdata  =
    in_bank   ? {24'h0, tx_timeslot_signaling_reg[bank_idx]} :
    is_ctrl   ? {27'h0, ctrl} :
    is_status ? status_word : 32'h0;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata <= 32'h0;
    end else if (setup && !PWRITE_IN) begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Signaling source selection
  // ****************************************
  wire logic       cas_en    = ctrl[CTL_CAS_EN];
  wire logic       mux_on    = ctrl[CTL_MUX_ON];
  wire logic [1:0] rate_mode = ctrl[CTL_MODE_LSB +: 2];
  wire logic       sigif_on  = ctrl[CTL_SIGIF_ON];
  wire logic [7:0] cur       = tx_timeslot_signaling_reg[SIG_IN.ts];
  wire logic [1:0] sel       = cur[SRC_LSB +: 2];
  wire logic [3:0] reg_abcd  = {cur[SIG_A_BIT], cur[SIG_B_BIT],
                                cur[SIG_C_BIT], cur[SIG_D_BIT]};
  wire logic [3:0] xyxx      = {cur[SIG_A_BIT], ALARM_IN,
                                cur[SIG_C_BIT], cur[SIG_D_BIT]};
  wire logic       base_rate = !mux_on && rate_mode == 2'h0 && !sigif_on;

  // Pin selection outside base rate with the flag clear has no defined
  // source, so the PCM nibble is passed on there with the insert flag still set.
  wire logic [3:0] next_abcd =
    !cas_en                       ? SIG_IN.pcm :
    sel == SRC_REG                ? reg_abcd :
    sel == SRC_PIN && sigif_on    ? SIG_IN.sig_pin :
    sel == SRC_PIN && base_rate   ? SIG_IN.overhead :
    sel == SRC_XYXX               ? xyxx :
    SIG_IN.pcm;
  wire logic next_insert = cas_en && sel != SRC_XYXX && sel != SRC_PCM;
  wire logic next_xyxx   = cas_en && sel == SRC_XYXX;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      SIG_VALID_OUT <= 1'b0;
      SIG_OUT       <= '0;
    end else begin
      SIG_VALID_OUT <= SIG_VALID_IN;
      if (SIG_VALID_IN) begin
        SIG_OUT <= '{abcd: next_abcd, insert: next_insert, xyxx: next_xyxx, src: sel};
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_reg_sel;
    SIG_VALID_IN && cas_en && sel == SRC_REG;
  endsequence

  property p_reg_src;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_reg_sel |=> SIG_OUT.abcd == $past(reg_abcd) && SIG_OUT.insert;
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("register source wrong");

  property p_pcm_src;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && cas_en && sel == SRC_PCM |=> SIG_OUT.abcd == $past(SIG_IN.pcm)
        && !SIG_OUT.insert;
  endproperty
  a_pcm_src: assert property (p_pcm_src) else $error("pcm pass wrong");

  property p_oh_src;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && cas_en && sel == SRC_PIN && base_rate
        |=> SIG_OUT.abcd == $past(SIG_IN.overhead);
  endproperty
  a_oh_src: assert property (p_oh_src) else $error("overhead source wrong");

  property p_pin_src;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && cas_en && sel == SRC_PIN && sigif_on
        |=> SIG_OUT.abcd == $past(SIG_IN.sig_pin);
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("signaling pin wrong");

  // Outside base rate with the flag clear the pin has no source, so PCM passes
  property p_pin_fallback;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && cas_en && sel == SRC_PIN && !sigif_on && !base_rate
        |=> SIG_OUT.abcd == $past(SIG_IN.pcm) && SIG_OUT.insert;
  endproperty
  a_pin_fallback: assert property (p_pin_fallback) else $error("pin fallback wrong");

  property p_cas_off;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && !cas_en
        |=> SIG_OUT.abcd == $past(SIG_IN.pcm) && !SIG_OUT.insert && !SIG_OUT.xyxx;
  endproperty
  a_cas_off: assert property (p_cas_off) else $error("cas off not transparent");

  sequence s_take;
    SIG_VALID_IN;
  endsequence

  property p_strobe;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_take |=> SIG_VALID_OUT;
  endproperty
  a_strobe: assert property (p_strobe) else $error("result strobe missing");

  // Downstream framing relies on the nibble standing between strobes
  property p_hold;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !SIG_VALID_IN |=> !SIG_VALID_OUT && $stable(SIG_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without strobe");

  property p_xyxx;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      SIG_VALID_IN && cas_en && sel == SRC_XYXX
        |=> !SIG_OUT.insert && SIG_OUT.xyxx && SIG_OUT.abcd[2] == $past(ALARM_IN)
            && SIG_OUT.abcd[3] == $past(cur[SIG_A_BIT]);
  endproperty
  a_xyxx: assert property (p_xyxx) else $error("xyxx handling wrong");

  property p_reserved;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      setup && !PWRITE_IN && in_bank |=> rdata[3:2] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_map;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      wr_access && in_bank |=> tx_timeslot_signaling_reg[$past(bank_idx)]
        == ($past(PWDATA_IN[7:0]) & WRITE_MASK);
  endproperty
  a_map: assert property (p_map) else $error("bank write landed wrong");

  property p_reset;
    @(posedge CLOCK_IN)
      $rose(RSTN_IN) |-> tx_timeslot_signaling_reg[TS_XYXX] == TS16_RESET
        && tx_timeslot_signaling_reg[1] == TS_RESET
        && tx_timeslot_signaling_reg[0] == TS0_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

endmodule : ecs_tx_cas_sel

// ### src/ecs_pkg.sv
package ecs_pkg;

  // ****************************************
  // Register map (word index, byte address is four times it)
  // ****************************************
  localparam int unsigned NUM_TS          = 32;
  localparam logic [11:0] SIG_BANK_INDEX  = 12'h340;
  localparam logic [11:0] CTRL_INDEX      = 12'h380;
  localparam logic [11:0] STATUS_INDEX    = 12'h381;
  localparam logic [13:0] SIG_BANK_ADDR   = {SIG_BANK_INDEX, 2'b00};
  localparam logic [13:0] CTRL_ADDR       = {CTRL_INDEX, 2'b00};
  localparam logic [13:0] STATUS_ADDR     = {STATUS_INDEX, 2'b00};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned SIG_A_BIT       = 7;
  localparam int unsigned SIG_B_BIT       = 6;
  localparam int unsigned SIG_C_BIT       = 5;
  localparam int unsigned SIG_D_BIT       = 4;
  localparam int unsigned SRC_LSB         = 0;
  localparam logic [7:0]  WRITE_MASK      = 8'hf3;
  localparam logic [7:0]  TS0_RESET       = 8'h01;
  localparam logic [7:0]  TS16_RESET      = 8'hb3;
  localparam logic [7:0]  TS_RESET        = 8'hd0;
  localparam int unsigned TS_XYXX         = 16;

  localparam logic [1:0]  SRC_PCM         = 2'h0;
  localparam logic [1:0]  SRC_REG         = 2'h1;
  localparam logic [1:0]  SRC_PIN         = 2'h2;
  localparam logic [1:0]  SRC_XYXX        = 2'h3;

  // Control register fields
  localparam int unsigned CTL_CAS_EN      = 0;
  localparam int unsigned CTL_MUX_ON      = 1;
  localparam int unsigned CTL_MODE_LSB    = 2;
  localparam int unsigned CTL_SIGIF_ON    = 4;
  localparam logic [4:0]  CTRL_MASK       = 5'h1f;

  typedef struct packed {
    logic [4:0] ts;
    logic [3:0] pcm;
    logic [3:0] overhead;
    logic [3:0] sig_pin;
  } ecs_sig_in_t;

  typedef struct packed {
    logic [3:0] abcd;
    logic       insert;
    logic       xyxx;
    logic [1:0] src;
  } ecs_sig_out_t;

endpackage : ecs_pkg

// ### verification/ecs_sig_src.sv
`timescale 1ns/1ps
module ecs_sig_src
  import ecs_pkg::*;
#(
  parameter logic [3:0] PCM = 4'h3,
  parameter logic [3:0] OH  = 4'h5,
  parameter logic [3:0] SP  = 4'h6
) (
  input  wire logic  clk_in,    // Bench clock
  output ecs_sig_in_t sig_out,  // Timeslot and candidate nibbles
  output logic       vld_out,   // Timeslot strobe
  output logic       alarm_out  // Alarm level
);
  initial begin
    sig_out   = '{5'h00, ~PCM, ~OH, ~SP};
    vld_out   = 1'b0;
    alarm_out = 1'b0;
  end

  // Idle pins show inverted nibbles so a stale sample can never match
  task automatic send(input logic [4:0] ts, input logic al);
    @(posedge clk_in);
    vld_out   <= 1'b1;
    sig_out   <= '{ts, PCM, OH, SP};
    alarm_out <= al;
    @(posedge clk_in);
    vld_out   <= 1'b0;
    sig_out   <= '{ts, ~PCM, ~OH, ~SP};
  endtask : send
endmodule : ecs_sig_src

// ### verification/tb_e1_tx_cas_signaling_select.sv
`timescale 1ns/1ps
module tb_e1_tx_cas_signaling_select;
  import ecs_pkg::*;
  typedef struct packed {
    logic [4:0] ts;
    logic [7:0] rg;
    logic [4:0] ctl;
    logic       al;
    logic [7:0] ex;
  } ecs_row_t;
  logic         clk, rstn, psel, pen, pwr, pready, perr, vin, vout, alarm, e;
  logic [13:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  ecs_sig_in_t  sin;
  ecs_sig_out_t sout;
  int           failures, n_tests;
  // Rows: timeslot, register, control, alarm, expected {abcd,insert,xyxx,src}
  ecs_row_t     rows [11] = '{
    '{5'd0, 8'h01, 5'h01, 1'b0, 8'h09}, '{5'd5, 8'had, 5'h01, 1'b0, 8'ha9},
    '{5'd6, 8'h9c, 5'h01, 1'b0, 8'h30}, '{5'd7, 8'h52, 5'h01, 1'b0, 8'h5a},
    '{5'd8, 8'h52, 5'h11, 1'b0, 8'h6a}, '{5'd16, 8'hf3, 5'h01, 1'b0, 8'hb7},
    '{5'd16, 8'h33, 5'h01, 1'b1, 8'h77}, '{5'd31, 8'ha1, 5'h00, 1'b0, 8'h31},
    '{5'd9, 8'h52, 5'h03, 1'b0, 8'h3a}, '{5'd12, 8'h52, 5'h05, 1'b0, 8'h3a},
    '{5'd13, 8'h52, 5'h13, 1'b0, 8'h6a}};

  ecs_tx_cas_sel dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .SIG_VALID_IN(vin), .SIG_IN(sin),
    .ALARM_IN(alarm), .SIG_VALID_OUT(vout), .SIG_OUT(sout));
  ecs_sig_src src (.clk_in(clk), .sig_out(sin), .vld_out(vin), .alarm_out(alarm));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [13:0] bank(input int k);
    return SIG_BANK_ADDR + 14'(4 * k);
  endfunction : bank

  // Starts one edge after entry so a release never meets a new request
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    final_report();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, pen, pwr, paddr, pwdata} = '0;
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < NUM_TS; k++) begin
      apb(1'b0, bank(k), '0);
      check(q, {24'h0, k == 0 ? TS0_RESET : k == 16 ? TS16_RESET : TS_RESET}, "reset");
    end
    $display("reset values done");
    foreach (rows[i]) begin
      apb(1'b1, CTRL_ADDR, {27'h0, rows[i].ctl});
      apb(1'b1, bank(rows[i].ts), {24'h0, rows[i].rg});
      apb(1'b0, bank(rows[i].ts), '0);
      check(q, {24'h0, rows[i].rg & 8'hf3}, "readback");
      src.send(rows[i].ts, rows[i].al);
      #1;
      check({31'h0, vout}, 32'h1, "strobe");
      check({24'h0, sout}, {24'h0, rows[i].ex}, "signaling");
      @(posedge clk);
      #1;
      check({31'h0, vout}, 32'h0, "strobe ends");
      $display("row %0d done", i);
    end
    apb(1'b0, STATUS_ADDR, '0);
    check(q, 32'h6, "status after last row");
    apb(1'b0, CTRL_ADDR, '0);
    check(q, 32'h13, "control readback");
    apb(1'b0, bank(10), '0);
    check(q, 32'hd0, "untouched slot");
    apb(1'b1, 14'h0100, 32'h5a);
    check({31'h0, e}, 32'h1, "unmapped error");
    apb(1'b0, 14'h0100, '0);
    check(q, '0, "unmapped read");
    $display("unmapped done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, bank(5), '0);
    check(q, 32'hd0, "second reset");
    $display("second reset done");
    final_report();
  end
endmodule : tb_e1_tx_cas_signaling_select
